/* File: core/pcm_port_c_ctrl.sv */
// Port C direction and function-select registers with APB access
//
// Local design decisions: the register offsets and the APB interface to the registers.
`default_nettype none

module pcm_port_c_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [20:0] pinIn,
	output logic      [20:0] pinOut,
	output logic      [20:0] pinOe,
	input  wire logic [20:0] portDataOut,
	output logic      [20:0] portDataIn,
	input  wire logic        wolOut,
	input  wire logic        extOut,
	input  wire logic        mdcOut,
	input  wire logic        mdioOut,
	input  wire logic        mdioOe,
	input  wire logic        txEnOut,
	input  wire logic        txErOut,
	output logic             linkStatusIn,
	output logic             mdioIn,
	output logic             crsIn,
	output logic             colIn,
	output logic             txClkIn
);

	logic [15:0] dirHigh_q;
	logic [15:0] dirLow_q;
	logic [15:0] fselHigh_q;
	logic [15:0] fselLowFirst_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [20:0] pinSync1_q;
	logic [20:0] pinSync2_q;
	logic [20:0] pinOut_q;
	logic [20:0] pinOe_q;
	logic [20:0] portDataIn_q;
	logic        linkStatus_q;
	logic        mdioIn_q;
	logic        crs_q;
	logic        col_q;
	logic        txClk_q;
	logic [20:0] muxOe;
	logic [20:0] muxOut;
	logic        setupPhase;
	logic        accessWrite;
	logic [9:0]  fselVec;

	pcm_cfg_if cfgBus ();

	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == pcm_pkg::OFF_DIR_HIGH) || (a == pcm_pkg::OFF_DIR_LOW)
			|| (a == pcm_pkg::OFF_FSEL_HIGH) || (a == pcm_pkg::OFF_FSEL_LOW_FIRST);
	endfunction

	function automatic logic [15:0] maskWrite(input logic [31:0] d, input logic [15:0] m);
		maskWrite = d[15:0] & m;
	endfunction

	assign setupPhase = psel && !penable && !pready_q;
	assign accessWrite = psel && penable && pready_q && pwrite;

	// Access phase always one cycle: ready raised right after setup
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setupPhase;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= setupPhase && !isMapped(paddr);
		end
	end

	// Read data captured at setup, stable through the access phase
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
		end else if (setupPhase && !pwrite) begin
			case (paddr)
				pcm_pkg::OFF_DIR_HIGH: prdata_q <= {16'h0000, dirHigh_q};
				pcm_pkg::OFF_DIR_LOW: prdata_q <= {16'h0000, dirLow_q};
				pcm_pkg::OFF_FSEL_HIGH: prdata_q <= {16'h0000, fselHigh_q};
				pcm_pkg::OFF_FSEL_LOW_FIRST: prdata_q <= {16'h0000, fselLowFirst_q};
				default: prdata_q <= 32'h00000000;
			endcase
		end else if (setupPhase) begin
			prdata_q <= 32'h00000000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dirHigh_q <= pcm_pkg::RST_DIR;
			dirLow_q <= pcm_pkg::RST_DIR;
		end else if (accessWrite && paddr == pcm_pkg::OFF_DIR_HIGH) begin
			dirHigh_q <= maskWrite(pwdata, pcm_pkg::MASK_DIR_HIGH);
		end else if (accessWrite && paddr == pcm_pkg::OFF_DIR_LOW) begin
			dirLow_q <= maskWrite(pwdata, pcm_pkg::MASK_DIR_LOW);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fselHigh_q <= pcm_pkg::RST_FSEL;
			fselLowFirst_q <= pcm_pkg::RST_FSEL;
		end else if (accessWrite && paddr == pcm_pkg::OFF_FSEL_HIGH) begin
			fselHigh_q <= maskWrite(pwdata, pcm_pkg::MASK_FSEL_HIGH);
		end else if (accessWrite && paddr == pcm_pkg::OFF_FSEL_LOW_FIRST) begin
			fselLowFirst_q <= maskWrite(pwdata, pcm_pkg::MASK_FSEL_LOW_FIRST);
		end
	end

	assign cfgBus.dirBits = {dirHigh_q[4:0], dirLow_q};
	assign fselVec = {
		fselHigh_q[pcm_pkg::BIT_PIN20], fselHigh_q[pcm_pkg::BIT_PIN19],
		fselHigh_q[pcm_pkg::BIT_PIN18], fselHigh_q[pcm_pkg::BIT_PIN17],
		fselHigh_q[pcm_pkg::BIT_PIN16], fselLowFirst_q[pcm_pkg::BIT_PIN15],
		fselLowFirst_q[pcm_pkg::BIT_PIN14], fselLowFirst_q[pcm_pkg::BIT_PIN13],
		fselLowFirst_q[pcm_pkg::BIT_PIN12], fselLowFirst_q[pcm_pkg::BIT_PIN11]
	};
	assign cfgBus.fselBits = fselVec;

	pcm_pin_mux u_mux (
		.cfg         (cfgBus),
		.portOut     (portDataOut),
		.wolOut      (wolOut),
		.extOut      (extOut),
		.mdcOut      (mdcOut),
		.mdioOut     (mdioOut),
		.mdioOe      (mdioOe),
		.txEnOut     (txEnOut),
		.txErOut     (txErOut),
		.muxOe       (muxOe),
		.muxOut      (muxOut)
	);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pinOe_q <= 21'h000000;
			pinOut_q <= 21'h000000;
		end else begin
			pinOe_q <= muxOe;
			pinOut_q <= muxOut;
		end
	end

	// Pin inputs through two flops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pinSync1_q <= 21'h000000;
			pinSync2_q <= 21'h000000;
		end else begin
			pinSync1_q <= pinIn;
			pinSync2_q <= pinSync1_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			portDataIn_q <= 21'h000000;
		end else begin
			portDataIn_q <= pinSync2_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			linkStatus_q <= 1'b0;
			mdioIn_q <= 1'b0;
			crs_q <= 1'b0;
			col_q <= 1'b0;
			txClk_q <= 1'b0;
		end else begin
			linkStatus_q <= fselVec[pcm_pkg::PIN_LINK - pcm_pkg::FIRST_MUX_PIN]
				&& pinSync2_q[pcm_pkg::PIN_LINK];
			mdioIn_q <= fselVec[pcm_pkg::PIN_MDIO - pcm_pkg::FIRST_MUX_PIN]
				&& pinSync2_q[pcm_pkg::PIN_MDIO];
			crs_q <= fselVec[pcm_pkg::PIN_CRS - pcm_pkg::FIRST_MUX_PIN]
				&& pinSync2_q[pcm_pkg::PIN_CRS];
			col_q <= fselVec[pcm_pkg::PIN_COL - pcm_pkg::FIRST_MUX_PIN]
				&& pinSync2_q[pcm_pkg::PIN_COL];
			txClk_q <= fselVec[pcm_pkg::PIN_TX_CLK - pcm_pkg::FIRST_MUX_PIN]
				&& pinSync2_q[pcm_pkg::PIN_TX_CLK];
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pinOut = pinOut_q;
	assign pinOe = pinOe_q;
	assign portDataIn = portDataIn_q;
	assign linkStatusIn = linkStatus_q;
	assign mdioIn = mdioIn_q;
	assign crsIn = crs_q;
	assign colIn = col_q;
	assign txClkIn = txClk_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_reset_all_zero: assert property (
		disable iff (1'b0) !rst_n |=> (dirHigh_q == 16'h0000 && dirLow_q == 16'h0000
			&& fselHigh_q == 16'h0000 && fselLowFirst_q == 16'h0000)
	) else $error("registers not cleared by reset");

	a_apb_ready_timing: assert property (
		setupPhase |=> pready_q ##1 !pready_q
	) else $error("ready not one cycle after setup");

	a_dir_low_write: assert property (
		accessWrite && paddr == pcm_pkg::OFF_DIR_LOW |=> dirLow_q == $past(pwdata[15:0])
	) else $error("direction low write lost");

	a_dir_high_resv: assert property (
		setupPhase && !pwrite && paddr == pcm_pkg::OFF_DIR_HIGH |=> prdata_q[31:5] == 27'h0
	) else $error("direction high reserved bits read nonzero");

	a_fsel_resv_read: assert property (
		setupPhase && !pwrite && paddr == pcm_pkg::OFF_FSEL_HIGH
			|=> (prdata_q[15:9] == 7'h00 && prdata_q[7] == 1'b0 && prdata_q[1] == 1'b0)
	) else $error("select high reserved bits read nonzero");

	a_port_pin_dir: assert property (
		1'b1 |=> pinOe_q[10:0] == $past(dirLow_q[10:0])
	) else $error("low pins not following direction");

	a_wol_owns_pin: assert property (
		fselHigh_q[pcm_pkg::BIT_PIN20] |=> pinOe_q[20] && pinOut_q[20] == $past(wolOut)
	) else $error("wake output not on pin 20");

	a_link_pin_input: assert property (
		fselHigh_q[pcm_pkg::BIT_PIN18] |=> !pinOe_q[18]
	) else $error("link status pin driven");

	a_mdio_dir: assert property (
		fselHigh_q[pcm_pkg::BIT_PIN16] |=> pinOe_q[16] == $past(mdioOe)
	) else $error("management data direction wrong");

	a_crs_gated: assert property (
		!fselLowFirst_q[pcm_pkg::BIT_PIN15] |=> !crs_q
	) else $error("carrier sense passed in port mode");

	a_high_port_dir: assert property (
		!fselHigh_q[pcm_pkg::BIT_PIN17] |=> pinOe_q[17] == $past(dirHigh_q[1])
	) else $error("pin 17 not following direction");

	a_ext_owns_pin: assert property (
		fselHigh_q[pcm_pkg::BIT_PIN19]
			|=> pinOe_q[19] && pinOut_q[19] == $past(extOut)
	) else $error("external output not on pin 19");

	a_mdc_owns_pin: assert property (
		fselHigh_q[pcm_pkg::BIT_PIN17]
			|=> pinOe_q[17] && pinOut_q[17] == $past(mdcOut)
	) else $error("management clock not on pin 17");

	a_txen_owns_pin: assert property (
		fselLowFirst_q[pcm_pkg::BIT_PIN12]
			|=> pinOe_q[12] && pinOut_q[12] == $past(txEnOut)
	) else $error("transmit enable not on pin 12");

	a_txer_owns_pin: assert property (
		fselLowFirst_q[pcm_pkg::BIT_PIN11]
			|=> pinOe_q[11] && pinOut_q[11] == $past(txErOut)
	) else $error("transmit error not on pin 11");

	a_link_pin_level: assert property (
		fselHigh_q[pcm_pkg::BIT_PIN18]
			|=> linkStatus_q == $past(pinSync2_q[pcm_pkg::PIN_LINK])
	) else $error("link status not following pin 18");

	a_link_gated: assert property (
		!fselHigh_q[pcm_pkg::BIT_PIN18] |=> !linkStatus_q
	) else $error("link status passed in port mode");

	a_mdio_in_gated: assert property (
		!fselHigh_q[pcm_pkg::BIT_PIN16] |=> !mdioIn_q
	) else $error("management data passed in port mode");

	a_crs_pin_input: assert property (
		fselLowFirst_q[pcm_pkg::BIT_PIN15]
			|=> !pinOe_q[15] && crs_q == $past(pinSync2_q[pcm_pkg::PIN_CRS])
	) else $error("carrier sense pin wrong");

	a_col_pin_input: assert property (
		fselLowFirst_q[pcm_pkg::BIT_PIN14]
			|=> !pinOe_q[14] && col_q == $past(pinSync2_q[pcm_pkg::PIN_COL])
	) else $error("collision pin wrong");

	a_txclk_pin_input: assert property (
		fselLowFirst_q[pcm_pkg::BIT_PIN13]
			|=> !pinOe_q[13] && txClk_q == $past(pinSync2_q[pcm_pkg::PIN_TX_CLK])
	) else $error("transmit clock pin wrong");

	a_high_pins_port: assert property (
		fselHigh_q == 16'h0000 |=> pinOe_q[20:16] == $past(dirHigh_q[4:0])
	) else $error("high pins not following direction");

	a_low_pins_port: assert property (
		fselLowFirst_q == 16'h0000 |=> pinOe_q[15:11] == $past(dirLow_q[15:11])
	) else $error("low select pins not following direction");

	a_port_out_value: assert property (
		fselHigh_q == 16'h0000 && fselLowFirst_q == 16'h0000
			|=> pinOut_q == $past(portDataOut)
	) else $error("port data not on pins");

	a_dir_high_write: assert property (
		accessWrite && paddr == pcm_pkg::OFF_DIR_HIGH
			|=> dirHigh_q == ($past(pwdata[15:0]) & pcm_pkg::MASK_DIR_HIGH)
	) else $error("direction high write wrong");

	a_fsel_high_write: assert property (
		accessWrite && paddr == pcm_pkg::OFF_FSEL_HIGH
			|=> fselHigh_q == ($past(pwdata[15:0]) & pcm_pkg::MASK_FSEL_HIGH)
	) else $error("select high write wrong");

	a_fsel_low_write: assert property (
		accessWrite && paddr == pcm_pkg::OFF_FSEL_LOW_FIRST
			|=> fselLowFirst_q == ($past(pwdata[15:0]) & pcm_pkg::MASK_FSEL_LOW_FIRST)
	) else $error("select low write wrong");

	a_fsel_low_resv: assert property (
		setupPhase && !pwrite && paddr == pcm_pkg::OFF_FSEL_LOW_FIRST
			|=> (prdata_q & ~{16'h0000, pcm_pkg::MASK_FSEL_LOW_FIRST}) == 32'h00000000
	) else $error("select low reserved bits read nonzero");

	a_unmapped_error: assert property (
		setupPhase && !isMapped(paddr) |=> pready_q && pslverr_q
	) else $error("unmapped address without error");

	a_reset_pins_input: assert property (
		disable iff (1'b0) !rst_n |=> pinOe_q == 21'h000000 && pinOut_q == 21'h000000
	) else $error("pins driven after reset");

endmodule

`default_nettype wire

/* File: core/pcm_pkg.sv */
// Constants and register layout for the port C pin controller
// How it works
// - Direction bit one drives the pin as output; zero makes it an input.
// - Combined direction bit n controls port C pin n, pins 20 to 0.
// - High direction bits act on pins 20 to 16 only in port mode.
// - Low direction bits act on pins 15 to 11 only in port mode, on pins 10 to 0 always.
// - High direction bits 15 to 5 read zero; software writes zero.
// - Both direction registers reset to zero, all pins inputs.
// - Direction and function-select registers are 16 bits, read/write.
// - High function-select bits 15 to 9 and odd 7 to 1 read zero.
// - High select bit 8 gives pin 20 the wake-on-LAN output.
// - High select bit 6 gives pin 19 the external output.
// - High select bit 4 feeds pin 18 as link-status input.
// - High select bit 2 drives the management clock on pin 17.
// - High select bit 0 connects bidirectional management data to pin 16.
// - Low select bit 14 feeds pin 15 as carrier sense input.
// - Low select bit 12 feeds pin 14 as collision input.
// - Low select bit 10 feeds pin 13 as transmit clock input.
// - Low select bit 8 drives transmit enable on pin 12.
// - Low select bit 15 and odd bits down to 7 read zero.
// - Every function-select bit resets to zero, pins in port mode.
// - Low select bit 6 drives transmit error on pin 11.
`default_nettype none

package pcm_pkg;

	localparam int PIN_COUNT = 21;
	localparam int FSEL_COUNT = 10;

	localparam logic [11:0] OFF_DIR_HIGH = 12'h000;
	localparam logic [11:0] OFF_DIR_LOW = 12'h004;
	localparam logic [11:0] OFF_FSEL_HIGH = 12'h008;
	localparam logic [11:0] OFF_FSEL_LOW_FIRST = 12'h00c;

	localparam logic [15:0] RST_DIR = 16'h0000;
	localparam logic [15:0] RST_FSEL = 16'h0000;

	localparam logic [15:0] MASK_DIR_HIGH = 16'h001f;
	localparam logic [15:0] MASK_DIR_LOW = 16'hffff;
	localparam logic [15:0] MASK_FSEL_HIGH = 16'h0155;
	localparam logic [15:0] MASK_FSEL_LOW_FIRST = 16'h5540;

	localparam int BIT_PIN20 = 8;
	localparam int BIT_PIN19 = 6;
	localparam int BIT_PIN18 = 4;
	localparam int BIT_PIN17 = 2;
	localparam int BIT_PIN16 = 0;
	localparam int BIT_PIN15 = 14;
	localparam int BIT_PIN14 = 12;
	localparam int BIT_PIN13 = 10;
	localparam int BIT_PIN12 = 8;
	localparam int BIT_PIN11 = 6;

	localparam int PIN_WOL = 20;
	localparam int PIN_EXT_OUT = 19;
	localparam int PIN_LINK = 18;
	localparam int PIN_MDC = 17;
	localparam int PIN_MDIO = 16;
	localparam int PIN_CRS = 15;
	localparam int PIN_COL = 14;
	localparam int PIN_TX_CLK = 13;
	localparam int PIN_TX_EN = 12;
	localparam int PIN_TX_ER = 11;
	localparam int FIRST_MUX_PIN = 11;

endpackage

`default_nettype wire

/* File: core/pcm_cfg_if.sv */
// Configuration carried from the register file to the pin multiplexer
`default_nettype none

interface pcm_cfg_if;
	logic [20:0] dirBits;
	logic [9:0]  fselBits;

	modport regs (output dirBits, output fselBits);
	modport mux (input dirBits, input fselBits);
endinterface

`default_nettype wire

/* File: core/pcm_pin_mux.sv */
// Per-pin direction and output selection between port and Ethernet
`default_nettype none

module pcm_pin_mux (
	pcm_cfg_if.mux      cfg,
	input  wire logic [20:0] portOut,
	input  wire logic        wolOut,
	input  wire logic        extOut,
	input  wire logic        mdcOut,
	input  wire logic        mdioOut,
	input  wire logic        mdioOe,
	input  wire logic        txEnOut,
	input  wire logic        txErOut,
	output logic      [20:0] muxOe,
	output logic      [20:0] muxOut
);

	function automatic logic selOf(input logic [9:0] f, input int pin);
		selOf = f[pin - pcm_pkg::FIRST_MUX_PIN];
	endfunction

	always_comb begin
		muxOe = cfg.dirBits;
		muxOut = portOut;
		if (selOf(cfg.fselBits, pcm_pkg::PIN_WOL)) begin
			muxOe[pcm_pkg::PIN_WOL] = 1'b1;
			muxOut[pcm_pkg::PIN_WOL] = wolOut;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_EXT_OUT)) begin
			muxOe[pcm_pkg::PIN_EXT_OUT] = 1'b1;
			muxOut[pcm_pkg::PIN_EXT_OUT] = extOut;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_LINK)) begin
			muxOe[pcm_pkg::PIN_LINK] = 1'b0;
			muxOut[pcm_pkg::PIN_LINK] = 1'b0;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_MDC)) begin
			muxOe[pcm_pkg::PIN_MDC] = 1'b1;
			muxOut[pcm_pkg::PIN_MDC] = mdcOut;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_MDIO)) begin
			muxOe[pcm_pkg::PIN_MDIO] = mdioOe;
			muxOut[pcm_pkg::PIN_MDIO] = mdioOut;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_CRS)) begin
			muxOe[pcm_pkg::PIN_CRS] = 1'b0;
			muxOut[pcm_pkg::PIN_CRS] = 1'b0;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_COL)) begin
			muxOe[pcm_pkg::PIN_COL] = 1'b0;
			muxOut[pcm_pkg::PIN_COL] = 1'b0;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_TX_CLK)) begin
			muxOe[pcm_pkg::PIN_TX_CLK] = 1'b0;
			muxOut[pcm_pkg::PIN_TX_CLK] = 1'b0;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_TX_EN)) begin
			muxOe[pcm_pkg::PIN_TX_EN] = 1'b1;
			muxOut[pcm_pkg::PIN_TX_EN] = txEnOut;
		end
		if (selOf(cfg.fselBits, pcm_pkg::PIN_TX_ER)) begin
			muxOe[pcm_pkg::PIN_TX_ER] = 1'b1;
			muxOut[pcm_pkg::PIN_TX_ER] = txErOut;
		end
	end

endmodule

`default_nettype wire

/* File: verif/pcm_phy_model.sv */
// Far side of the pins: external transceiver levels resolved against device drive
`default_nettype none

module pcm_phy_model (
	input  wire logic [20:0] pinOut,
	input  wire logic [20:0] pinOe,
	input  wire logic [20:0] phyLevel,
	output logic      [20:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ns;

	// wire level
	// Device wins where it drives, transceiver level elsewhere
	always_comb begin
		pinIn = (pinOe & pinOut) | (~pinOe & phyLevel);
	end
endmodule

`default_nettype wire

/* File: verif/tb_port_c_direction_function_select.sv */
// Self-checking bench for the port C pin controller
`default_nettype none

module tb_port_c_direction_function_select;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [20:0] pinIn;
	logic [20:0] pinOut;
	logic [20:0] pinOe;
	logic [20:0] portDataOut = 21'h0aaaaa;
	logic [20:0] portDataIn;
	logic [20:0] phyLevel = 21'h1eec5d;
	logic        wolOut = 1'b1;
	logic        extOut = 1'b0;
	logic        mdcOut = 1'b1;
	logic        mdioOut = 1'b1;
	logic        mdioOe = 1'b1;
	logic        txEnOut = 1'b0;
	logic        txErOut = 1'b1;
	logic        linkStatusIn;
	logic        mdioIn;
	logic        crsIn;
	logic        colIn;
	logic        txClkIn;
	int          mismatches = 0;
	int          num_checks = 0;
	logic [11:0] offs [4];
	logic [15:0] msks [4];
	logic [31:0] rd;
	logic        er;
	logic [20:0] expOe;

	always #50 ref_clk = ~ref_clk;

	pcm_port_c_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.portDataOut(portDataOut), .portDataIn(portDataIn), .wolOut(wolOut),
		.extOut(extOut), .mdcOut(mdcOut), .mdioOut(mdioOut), .mdioOe(mdioOe),
		.txEnOut(txEnOut), .txErOut(txErOut), .linkStatusIn(linkStatusIn),
		.mdioIn(mdioIn), .crsIn(crsIn), .colIn(colIn), .txClkIn(txClkIn));

	pcm_phy_model phy (.pinOut(pinOut), .pinOe(pinOe), .phyLevel(phyLevel), .pinIn(pinIn));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Setup, then access held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_clks(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#(100 * 5000);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		offs = '{pcm_pkg::OFF_DIR_HIGH, pcm_pkg::OFF_DIR_LOW, pcm_pkg::OFF_FSEL_HIGH,
			pcm_pkg::OFF_FSEL_LOW_FIRST};
		msks = '{pcm_pkg::MASK_DIR_HIGH, pcm_pkg::MASK_DIR_LOW, pcm_pkg::MASK_FSEL_HIGH,
			pcm_pkg::MASK_FSEL_LOW_FIRST};
		wait_clks(5);
		rst_n <= 1'b1;
		// Reset values, then defined bits written and read back; reserved bits kept zero
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, offs[i], 32'h0, rd, er);
			check(rd, 32'h0);
			check(pinOe, 21'h0);
			apb(1'b1, offs[i], {16'h0000, msks[i]}, rd, er);
			apb(1'b0, offs[i], 32'h0, rd, er);
			check(rd, {16'h0, msks[i]});
			check(er, 1'b0);
			apb(1'b1, offs[i], 32'h0, rd, er);
		end
		apb(1'b0, 12'h010, 32'h0, rd, er);
		check(er, 1'b1);
		check(rd, 32'h0);
		$display("test registers done");
		// Port mode: direction bits steer every pin
		apb(1'b1, pcm_pkg::OFF_DIR_LOW, 32'h0000a5a5, rd, er);
		apb(1'b1, pcm_pkg::OFF_DIR_HIGH, 32'h00000015, rd, er);
		wait_clks(5);
		expOe = {5'h15, 16'ha5a5};
		check(pinOe, expOe);
		check(pinOut & expOe, portDataOut & expOe);
		check(portDataIn, (expOe & portDataOut) | (~expOe & phyLevel));
		$display("test direction done");
		// Function mode: all selects on, direction bits all ones
		apb(1'b1, pcm_pkg::OFF_DIR_LOW, 32'h0000ffff, rd, er);
		apb(1'b1, pcm_pkg::OFF_DIR_HIGH, 32'h0000001f, rd, er);
		apb(1'b1, pcm_pkg::OFF_FSEL_HIGH, {16'h0, pcm_pkg::MASK_FSEL_HIGH}, rd, er);
		apb(1'b1, pcm_pkg::OFF_FSEL_LOW_FIRST, {16'h0, pcm_pkg::MASK_FSEL_LOW_FIRST}, rd, er);
		wait_clks(5);
		check(pinOe, {10'h363, 11'h7ff});
		check(pinOut, {10'h261, portDataOut[10:0]});
		check(linkStatusIn, phyLevel[18]);
		check(mdioIn, mdioOut);
		check(crsIn, phyLevel[15]);
		check(colIn, phyLevel[14]);
		check(txClkIn, phyLevel[13]);
		mdioOe <= 1'b0;
		wolOut <= 1'b0;
		txEnOut <= 1'b1;
		extOut <= 1'b1;
		mdcOut <= 1'b0;
		txErOut <= 1'b0;
		wait_clks(5);
		check(pinOe[16], 1'b0);
		check(mdioIn, phyLevel[16]);
		check(pinOut[20], 1'b0);
		check(pinOut[12], 1'b1);
		check(pinOut[19], 1'b1);
		check(pinOut[17], 1'b0);
		check(pinOut[11], 1'b0);
		$display("test function done");
		// Back to port mode with high direction cleared, low direction left all ones
		apb(1'b1, pcm_pkg::OFF_FSEL_HIGH, 32'h0, rd, er);
		apb(1'b1, pcm_pkg::OFF_FSEL_LOW_FIRST, 32'h0, rd, er);
		apb(1'b1, pcm_pkg::OFF_DIR_HIGH, 32'h0, rd, er);
		wait_clks(5);
		check(pinOe, {5'h0, 16'hffff});
		check(linkStatusIn, 1'b0);
		check(crsIn, 1'b0);
		check(colIn, 1'b0);
		check(txClkIn, 1'b0);
		check(mdioIn, 1'b0);
		check(pinOut, portDataOut);
		$display("test release done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
